//--- logic/tpsc_params.svh
/*
  constants of the port status and control register bank: offsets,
  field positions, reset values, cc_settle_time and soft reset timing.
  assumes inclusion by bare name from the design files.
*/
`ifndef TPSC_PARAMS_SVH
`define TPSC_PARAMS_SVH

// register offsets and reset values
`define TPSC_OFF_CONN_STAT_CTL   8'h09
`define TPSC_OFF_GEN_CTL         8'h0A
`define TPSC_RST_CONN_STAT_CTL   8'h20
`define TPSC_RST_GEN_CTL         8'h00

// connection status and control fields
`define TPSC_ATTACH_HI           7
`define TPSC_ATTACH_LO           6
`define TPSC_ORIENT_BIT          5
`define TPSC_CHANGE_BIT          4
`define TPSC_OVERCUR_BIT         3
`define TPSC_SHARE_HI            2
`define TPSC_SHARE_LO            1
`define TPSC_ACC_OFF_BIT         0

// general control fields
`define TPSC_SETTLE_HI           7
`define TPSC_SETTLE_LO           6
`define TPSC_ROLE_HI             5
`define TPSC_ROLE_LO             4
`define TPSC_SOFT_RST_BIT        3
`define TPSC_PREF_HI             2
`define TPSC_PREF_LO             1
`define TPSC_TERM_OFF_BIT        0

// cc_settle_time times in ms, and clock rate
`define TPSC_CLK_KHZ             125000
`define TPSC_SETTLE_MS_0         168
`define TPSC_SETTLE_MS_1         118
`define TPSC_SETTLE_MS_2         134
`define TPSC_SETTLE_MS_3         152
`define TPSC_SETTLE_CYC(ms)      ((ms) * `TPSC_CLK_KHZ)

// dual-role share in percent
`define TPSC_SHARE_PCT_0         30
`define TPSC_SHARE_PCT_1         40
`define TPSC_SHARE_PCT_2         50
`define TPSC_SHARE_PCT_3         60

// soft reset length in cycles
`define TPSC_SOFT_RST_CYC        16

`endif

//--- logic/tpsc_pkg.sv
/*
  types of the port status and control register bank.
  assumes nothing of its surroundings.
*/
package tpsc_pkg;

  typedef enum logic [1:0] {
    TPSC_ATT_NONE   = 2'h0,
    TPSC_ATT_SOURCE = 2'h1,
    TPSC_ATT_SINK   = 2'h2,
    TPSC_ATT_ACC    = 2'h3
  } tpsc_attach_type;

  typedef enum logic [1:0] {
    TPSC_ROLE_DUAL  = 2'h0,
    TPSC_ROLE_SINK  = 2'h1,
    TPSC_ROLE_SRC   = 2'h2,
    TPSC_ROLE_DUAL2 = 2'h3
  } tpsc_role_type;

  typedef enum logic [1:0] {
    TPSC_PREF_STD  = 2'h0,
    TPSC_PREF_SNK  = 2'h1,
    TPSC_PREF_RSV  = 2'h2,
    TPSC_PREF_SRC  = 2'h3
  } tpsc_pref_type;

  typedef enum logic [1:0] {
    TPSC_SR_IDLE = 2'h0,
    TPSC_SR_BUSY = 2'h1,
    TPSC_SR_DONE = 2'h2
  } tpsc_sr_type;

endpackage

//--- logic/tpsc_port_status_control.sv
/*
  connection status/control and general control register bank of a
  usb type-c dual-role port controller, with role, duty share and
  cc cc_settle_time logic. assumes an i2c front end gives byte strobes
  with an offset, and cc detection gives raw attach facts.
*/
// Summary of operation
// RULE1: attach result 2-bit field at 7:6, mirrored on the attach indicator pin.
// RULE2: orientation bit 5; 0 means cc2, 1 means cc1 (default).
// RULE3: alert output goes low whenever a register value changes.
// RULE4: change flag set on change, held until host clears; 1 while alert low.
// RULE5: overcurrent flag bit 3 set when the cable power limit trips.
// RULE6: dual-role source share per toggle: 30, 40, 50, 60 percent.
// RULE7: sink accessory off bit disables accessories as sink.
// RULE8: cc cc_settle_time time 168, 118, 134 or 152 ms by field.
// RULE9: role field: 00/11 dual-role, 01 sink only, 10 source only.
// RULE10: register role used only in i2c mode and not at default; else straps.
// RULE11: role field changes accepted only while unattached.
// RULE12: soft reset bit starts a logic reset and clears itself when done.
// RULE13: soft reset may change detect, cable, accessory, attach, orientation.
// RULE14: preference: 00 standard, 01 try sink, 11 try source.
// RULE15: termination off bit removes terminations, holds machine disabled.
// RULE16: general control at 0x0A, after status/control at 0x09.
// RULE17: reads return msb first from the given offset; front end serialises.
// RULE18: reserved preference code acts as standard dual-role.
// RULE19: status field writes ignored; writing 1 to change flag clears it.
`timescale 1ns/100ps
`include "tpsc_params.svh"

module tpsc_port_status_control #(
  parameter int PERIOD_CYC = 10000,
  parameter int SETTLE_W   = 25,
  parameter int SET0       = `TPSC_SETTLE_CYC(`TPSC_SETTLE_MS_0),
  parameter int SET1       = `TPSC_SETTLE_CYC(`TPSC_SETTLE_MS_1),
  parameter int SET2       = `TPSC_SETTLE_CYC(`TPSC_SETTLE_MS_2),
  parameter int SET3       = `TPSC_SETTLE_CYC(`TPSC_SETTLE_MS_3)
) (
  // clock and reset
  input  wire logic       mclk,
  input  wire logic       reset_n,
  // register access from the i2c front end
  input  wire logic [7:0] reg_addr,
  input  wire logic       reg_wr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  // straps
  input  wire logic       i2c_mode_strap,
  input  wire logic [1:0] role_strap,
  // raw cc detection facts
  input  wire logic [1:0] cc_attach_raw,
  input  wire logic       cc_orient_raw,
  input  wire logic       cable_power_trip,
  // outputs
  output logic            change_alert_n,
  output logic [1:0]      attach_indicator_pin,
  output logic            source_advertise,
  output logic [1:0]      active_role,
  output logic            accessory_allow,
  output logic            cc_term_on,
  output logic [1:0]      try_mode,
  output logic            logic_reset
);

  initial begin
    if (PERIOD_CYC < 10 || PERIOD_CYC > 65535)
      $error("toggle period out of range");
  end

  typedef struct packed {
    logic [7:0]            csc;
    logic [7:0]            gc;
    tpsc_pkg::tpsc_sr_type sr;
    logic [4:0]            sr_cnt;
    logic [15:0]           tog;
    logic                  alert_n;
    logic [1:0]            att_pin;
    logic                  src_adv;
    logic [1:0]            role;
    logic                  acc;
    logic                  term;
    logic [1:0]            try_m;
    logic                  lrst;
    logic [7:0]            rdata;
  } tpsc_state_type;

  tpsc_state_type s_q, s_d;
  logic [2:0]  settled;
  logic [15:0] share_cyc;
  logic [1:0]  role_f;
  logic        changed;

  ////////////////////////////////////////////////////////////////////
  // cc_settle_time of attach and orientation; held in reset while soft reset runs
  tpsc_settle_timer #(
    .CNT_W (SETTLE_W),
    .T0    (SET0),
    .T1    (SET1),
    .T2    (SET2),
    .T3    (SET3),
    .W     (3)
  ) u_settle (
    .mclk    (mclk),
    .reset_n (reset_n && !s_q.lrst), // see RULE13
    .sel     (s_q.gc[`TPSC_SETTLE_HI:`TPSC_SETTLE_LO]), // see RULE8
    .raw     ({cc_attach_raw, cc_orient_raw}),
    .settled (settled)
  );

  ////////////////////////////////////////////////////////////////////
  always_comb begin
    s_d = s_q;
    changed = 1'b0;
    // status update: attach and orientation only when terminations are on
    if (!s_q.gc[`TPSC_TERM_OFF_BIT]) begin
      s_d.csc[`TPSC_ATTACH_HI:`TPSC_ATTACH_LO] = settled[2:1]; // see RULE1
      s_d.csc[`TPSC_ORIENT_BIT] = settled[0] | (settled[2:1] == 2'h0); // see RULE2
    end else begin
      s_d.csc[`TPSC_ATTACH_HI:`TPSC_ATTACH_LO] = 2'h0; // see RULE15
      s_d.csc[`TPSC_ORIENT_BIT] = 1'b1;
    end
    if (cable_power_trip) begin
      s_d.csc[`TPSC_OVERCUR_BIT] = 1'b1; // see RULE5
    end
    // host writes
    if (reg_wr && reg_addr == `TPSC_OFF_CONN_STAT_CTL) begin // see RULE16
      s_d.csc[`TPSC_SHARE_HI:`TPSC_ACC_OFF_BIT] = reg_wdata[2:0]; // see RULE19
      if (reg_wdata[`TPSC_CHANGE_BIT]) begin
        s_d.csc[`TPSC_CHANGE_BIT] = 1'b0; // see RULE19
      end
    end
    if (reg_wr && reg_addr == `TPSC_OFF_GEN_CTL) begin // see RULE16
      s_d.gc[`TPSC_SETTLE_HI:`TPSC_SETTLE_LO] = reg_wdata[7:6];
      s_d.gc[`TPSC_PREF_HI:`TPSC_TERM_OFF_BIT] = reg_wdata[2:0];
      if (s_q.csc[`TPSC_ATTACH_HI:`TPSC_ATTACH_LO] == 2'h0) begin
        s_d.gc[`TPSC_ROLE_HI:`TPSC_ROLE_LO] = reg_wdata[5:4]; // see RULE11
      end
      if (reg_wdata[`TPSC_SOFT_RST_BIT] && s_q.sr == tpsc_pkg::TPSC_SR_IDLE) begin
        s_d.gc[`TPSC_SOFT_RST_BIT] = 1'b1; // see RULE12
        s_d.sr = tpsc_pkg::TPSC_SR_BUSY;
        s_d.sr_cnt = 5'h00;
      end
    end
    // soft reset sequencing
    case (s_q.sr)
      tpsc_pkg::TPSC_SR_IDLE: s_d.lrst = 1'b0;
      tpsc_pkg::TPSC_SR_BUSY: begin
        s_d.lrst = 1'b1;
        s_d.sr_cnt = s_q.sr_cnt + 5'h01;
        if (s_q.sr_cnt == 5'(`TPSC_SOFT_RST_CYC - 1)) begin
          s_d.sr = tpsc_pkg::TPSC_SR_DONE;
        end
      end
      tpsc_pkg::TPSC_SR_DONE: begin
        s_d.lrst = 1'b0;
        s_d.gc[`TPSC_SOFT_RST_BIT] = 1'b0; // see RULE12
        s_d.sr = tpsc_pkg::TPSC_SR_IDLE;
      end
      default: s_d.sr = tpsc_pkg::TPSC_SR_IDLE;
    endcase
    // change detection on every bit except the flag itself; set beats clear
    changed = ({s_d.csc[7:5], s_d.csc[3:0], s_d.gc} != {s_q.csc[7:5], s_q.csc[3:0], s_q.gc});
    if (changed) begin
      s_d.csc[`TPSC_CHANGE_BIT] = 1'b1; // see RULE4
    end
    s_d.alert_n = !s_d.csc[`TPSC_CHANGE_BIT]; // see RULE3
    // role choice
    role_f = s_q.gc[`TPSC_ROLE_HI:`TPSC_ROLE_LO];
    if (i2c_mode_strap && role_f != 2'h0) begin
      s_d.role = (role_f == 2'h3) ? 2'h0 : role_f; // see RULE9
    end else begin
      s_d.role = (role_strap == 2'h3) ? 2'h0 : role_strap; // see RULE10
    end
    // dual-role toggle share
    case (s_q.csc[`TPSC_SHARE_HI:`TPSC_SHARE_LO])
      2'h0:    share_cyc = 16'((PERIOD_CYC * `TPSC_SHARE_PCT_0) / 100); // see RULE6
      2'h1:    share_cyc = 16'((PERIOD_CYC * `TPSC_SHARE_PCT_1) / 100);
      2'h2:    share_cyc = 16'((PERIOD_CYC * `TPSC_SHARE_PCT_2) / 100);
      default: share_cyc = 16'((PERIOD_CYC * `TPSC_SHARE_PCT_3) / 100);
    endcase
    s_d.tog = (s_q.tog >= 16'(PERIOD_CYC - 1)) ? 16'h0000 : s_q.tog + 16'h0001;
    case (s_q.role)
      2'h1:    s_d.src_adv = 1'b0;
      2'h2:    s_d.src_adv = 1'b1;
      default: s_d.src_adv = (s_q.tog < share_cyc); // see RULE6
    endcase
    if (s_q.gc[`TPSC_TERM_OFF_BIT]) begin
      s_d.src_adv = 1'b0; // see RULE15
    end
    s_d.term = !s_q.gc[`TPSC_TERM_OFF_BIT]; // see RULE15
    s_d.acc = !(s_q.csc[`TPSC_ACC_OFF_BIT] && !s_q.src_adv); // see RULE7
    case (s_q.gc[`TPSC_PREF_HI:`TPSC_PREF_LO])
      2'h1:    s_d.try_m = 2'h1; // see RULE14
      2'h3:    s_d.try_m = 2'h3;
      default: s_d.try_m = 2'h0; // see RULE18
    endcase
    if (s_q.role != 2'h0) begin
      s_d.try_m = 2'h0;
    end
    s_d.att_pin = s_q.csc[`TPSC_ATTACH_HI:`TPSC_ATTACH_LO]; // see RULE1
    // read data, whole byte; front end shifts it out msb first
    if (reg_rd) begin
      case (reg_addr)
        `TPSC_OFF_CONN_STAT_CTL: s_d.rdata = s_q.csc; // see RULE17
        `TPSC_OFF_GEN_CTL:       s_d.rdata = s_q.gc;
        default:                 s_d.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      s_q         <= '0;
      s_q.csc     <= `TPSC_RST_CONN_STAT_CTL;
      s_q.gc      <= `TPSC_RST_GEN_CTL;
      s_q.sr      <= tpsc_pkg::TPSC_SR_IDLE;
      s_q.alert_n <= 1'b1;
      s_q.acc     <= 1'b1;
      s_q.term    <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign reg_rdata            = s_q.rdata;
  assign change_alert_n       = s_q.alert_n;
  assign attach_indicator_pin = s_q.att_pin;
  assign source_advertise     = s_q.src_adv;
  assign active_role          = s_q.role;
  assign accessory_allow      = s_q.acc;
  assign cc_term_on           = s_q.term;
  assign try_mode             = s_q.try_m;
  assign logic_reset          = s_q.lrst;

  ////////////////////////////////////////////////////////////////////
  property p_alert_flag;
    @(posedge mclk) disable iff (!reset_n)
      !change_alert_n |-> s_q.csc[`TPSC_CHANGE_BIT];
  endproperty
  a_alert_flag: assert property (p_alert_flag) else $error("alert low, flag clear"); // see RULE4

  property p_overcur;
    @(posedge mclk) disable iff (!reset_n)
      cable_power_trip |=> s_q.csc[`TPSC_OVERCUR_BIT];
  endproperty
  a_overcur: assert property (p_overcur) else $error("overcurrent not flagged"); // see RULE5

  property p_change_alert;
    @(posedge mclk) disable iff (!reset_n)
      (s_q.gc != $past(s_q.gc)) |=> !change_alert_n;
  endproperty
  a_change_alert: assert property (p_change_alert) else $error("no alert on change"); // see RULE3

  property p_role_locked;
    @(posedge mclk) disable iff (!reset_n)
      (s_q.csc[7:6] != 2'h0) |=> $stable(s_q.gc[5:4]);
  endproperty
  a_role_locked: assert property (p_role_locked) else $error("role changed attached"); // see RULE11

  property p_term_off;
    @(posedge mclk) disable iff (!reset_n)
      s_q.gc[`TPSC_TERM_OFF_BIT] |=> (!cc_term_on && !source_advertise);
  endproperty
  a_term_off: assert property (p_term_off) else $error("terminations still on"); // see RULE15

  // machine held disabled: no attach can be reported with terminations removed
  property p_term_attach;
    @(posedge mclk) disable iff (!reset_n)
      s_q.gc[`TPSC_TERM_OFF_BIT] |=> (s_q.csc[`TPSC_ATTACH_HI:`TPSC_ATTACH_LO] == 2'h0);
  endproperty
  a_term_attach: assert property (p_term_attach) else $error("attach with terms off"); // see RULE15

  property p_role_sink;
    @(posedge mclk) disable iff (!reset_n)
      (active_role == 2'h1) |=> !source_advertise;
  endproperty
  a_role_sink: assert property (p_role_sink) else $error("sink only advertised source"); // see RULE9

  property p_try_dual;
    @(posedge mclk) disable iff (!reset_n)
      (active_role != 2'h0) |=> (try_mode == 2'h0);
  endproperty
  a_try_dual: assert property (p_try_dual) else $error("try mode outside dual role"); // see RULE14

  property p_soft_rst;
    @(posedge mclk) disable iff (!reset_n)
      $rose(s_q.gc[`TPSC_SOFT_RST_BIT]) |-> ##[16:20] !s_q.gc[`TPSC_SOFT_RST_BIT];
  endproperty
  a_soft_rst: assert property (p_soft_rst) else $error("soft reset not cleared"); // see RULE12

  property p_pin_mirror;
    @(posedge mclk) disable iff (!reset_n)
      ##1 attach_indicator_pin == $past(s_q.csc[7:6]);
  endproperty
  a_pin_mirror: assert property (p_pin_mirror) else $error("pin not mirrored"); // see RULE1

  property p_reserved_pref;
    @(posedge mclk) disable iff (!reset_n)
      (s_q.gc[2:1] == 2'h2) |=> try_mode == 2'h0;
  endproperty
  a_reserved_pref: assert property (p_reserved_pref) else $error("reserved pref used"); // see RULE18

  c_alert:  cover property (@(posedge mclk) disable iff (!reset_n) $fell(change_alert_n));
  c_clear:  cover property (@(posedge mclk) disable iff (!reset_n) $rose(change_alert_n));
  c_softr:  cover property (@(posedge mclk) disable iff (!reset_n) $fell(logic_reset));
  c_attach: cover property (@(posedge mclk) disable iff (!reset_n) attach_indicator_pin == 2'h2);

endmodule // tpsc_port_status_control

//--- logic/tpsc_settle_timer.sv
/*
  cc line cc_settle_time timer: a level is passed once stable for the
  selected settle time. assumes inputs synchronous to mclk.
*/
`timescale 1ns/100ps
`include "tpsc_params.svh"

module tpsc_settle_timer #(
  parameter int CNT_W = 25,
  parameter int T0    = `TPSC_SETTLE_CYC(`TPSC_SETTLE_MS_0),
  parameter int T1    = `TPSC_SETTLE_CYC(`TPSC_SETTLE_MS_1),
  parameter int T2    = `TPSC_SETTLE_CYC(`TPSC_SETTLE_MS_2),
  parameter int T3    = `TPSC_SETTLE_CYC(`TPSC_SETTLE_MS_3),
  parameter int W     = 4
) (
  // clock and reset
  input  wire logic           mclk,
  input  wire logic           reset_n,
  // selection and data
  input  wire logic [1:0]     sel,
  input  wire logic [W-1:0]   raw,
  output logic      [W-1:0]   settled
);

  initial begin
    if (T0 >= (1 << CNT_W) || T1 >= (1 << CNT_W) || T2 >= (1 << CNT_W) ||
        T3 >= (1 << CNT_W) || T0 < 1 || T1 < 1 || T2 < 1 || T3 < 1)
      $error("settle counts do not fit the counter");
  end

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic [W-1:0]     last;
    logic [W-1:0]     out;
  } tpsc_st_type;

  tpsc_st_type st_q, st_d;
  logic [CNT_W-1:0] limit;

  ////////////////////////////////////////////////////////////////////
  always_comb begin
    case (sel)
      2'h0:    limit = CNT_W'(T0); // see RULE8
      2'h1:    limit = CNT_W'(T1);
      2'h2:    limit = CNT_W'(T2);
      default: limit = CNT_W'(T3);
    endcase
    st_d = st_q;
    st_d.last = raw;
    if (raw != st_q.last) begin
      st_d.cnt = '0;
    end else if (st_q.cnt >= limit - CNT_W'(1)) begin
      st_d.out = raw; // see RULE8
    end else begin
      st_d.cnt = st_q.cnt + CNT_W'(1);
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign settled = st_q.out;

endmodule // tpsc_settle_timer

//--- test/tpsc_cc_partner.sv
/*
  cc port partner model: shows attach code, orientation and cable
  power trip to the device. assumes the bench sets its wants.
*/
`timescale 1ns/100ps

module tpsc_cc_partner (
  // clock
  input  wire logic       mclk,
  // wants from the bench
  input  wire logic [1:0] want_attach,
  input  wire logic       want_orient,
  input  wire logic       want_trip,
  // cc facts seen by the device
  output logic      [1:0] cc_attach_raw,
  output logic            cc_orient_raw,
  output logic            cable_power_trip
);
  initial begin
    cc_attach_raw    = 2'h0;
    cc_orient_raw    = 1'b1;
    cable_power_trip = 1'b0;
  end

  // moves on the edge by nba so the device sees it one edge later
  always @(posedge mclk) begin
    cc_attach_raw    <= want_attach;
    cc_orient_raw    <= want_orient;
    cable_power_trip <= want_trip;
  end
endmodule // tpsc_cc_partner

//--- test/typec_port_status_control_test.sv
/*
  bench of the port status and control bank: access, cc_settle_time, roles,
  share, soft reset. assumes a 125 MHz mclk and shortened counts.
*/
`timescale 1ns/100ps

module typec_port_status_control_test;
  //////////////////////////////////////////////////////////////
  logic       mclk;
  logic       reset_n;
  logic [7:0] reg_addr;
  logic       reg_wr;
  logic [7:0] reg_wdata;
  logic       reg_rd;
  logic [7:0] reg_rdata;
  logic       i2c_mode_strap;
  logic [1:0] role_strap;
  logic [1:0] cc_attach_raw;
  logic       cc_orient_raw;
  logic       cable_power_trip;
  logic       change_alert_n;
  logic [1:0] attach_indicator_pin;
  logic       source_advertise;
  logic [1:0] active_role;
  logic       accessory_allow;
  logic       cc_term_on;
  logic [1:0] try_mode;
  logic       logic_reset;
  logic [1:0] want_attach;
  logic       want_orient;
  logic       want_trip;
  logic [7:0] seed;
  logic [7:0] d;
  int         errors;
  int         cmp_count;
  int         n;

  //////////////////////////////////////////////////////////////
  // short counts keep the run small
  tpsc_port_status_control #(.PERIOD_CYC(100), .SET0(20), .SET1(30), .SET2(40), .SET3(50))
  i_tpsc_port_status_control (
    .mclk(mclk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .i2c_mode_strap(i2c_mode_strap), .role_strap(role_strap),
    .cc_attach_raw(cc_attach_raw), .cc_orient_raw(cc_orient_raw),
    .cable_power_trip(cable_power_trip), .change_alert_n(change_alert_n),
    .attach_indicator_pin(attach_indicator_pin), .source_advertise(source_advertise),
    .active_role(active_role), .accessory_allow(accessory_allow),
    .cc_term_on(cc_term_on), .try_mode(try_mode), .logic_reset(logic_reset));

  tpsc_cc_partner i_tpsc_cc_partner (
    .mclk(mclk), .want_attach(want_attach), .want_orient(want_orient),
    .want_trip(want_trip), .cc_attach_raw(cc_attach_raw),
    .cc_orient_raw(cc_orient_raw), .cable_power_trip(cable_power_trip));

  always #4 mclk = ~mclk;

  //////////////////////////////////////////////////////////////
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  function automatic logic [1:0] exp_role(input logic [1:0] r);
    return (r == 2'h0) ? ((role_strap == 2'h3) ? 2'h0 : role_strap) : ((r == 2'h3) ? 2'h0 : r);
  endfunction

  function automatic logic [1:0] exp_try(input logic [1:0] p);
    return (p == 2'h2) ? 2'h0 : p;
  endfunction

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string msg);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge mclk);
    reg_addr  = a;
    reg_wdata = v;
    reg_wr    = 1'b1;
    @(negedge mclk);
    reg_wr = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(negedge mclk);
    reg_addr = a;
    reg_rd   = 1'b1;
    @(negedge mclk);
    reg_rd = 1'b0;
    d      = reg_rdata;
  endtask

  task automatic test_done();
    $display("checks %0d, mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  //////////////////////////////////////////////////////////////
  initial begin
    mclk           = 1'b0;
    reset_n        = 1'b0;
    reg_addr       = 8'h00;
    reg_wr         = 1'b0;
    reg_wdata      = 8'h00;
    reg_rd         = 1'b0;
    i2c_mode_strap = 1'b1;
    role_strap     = 2'h0;
    want_attach    = 2'h0;
    want_orient    = 1'b1;
    want_trip      = 1'b0;
    errors         = 0;
    cmp_count      = 0;
    seed           = 8'h18;
    repeat (8) @(negedge mclk);
    reset_n = 1'b1;
    chk(change_alert_n, 1'b1, "alert idle");
    rd(8'h09);
    chk(d, 8'h20, "status reset");
    rd(8'h0A);
    chk(d, 8'h00, "control reset");
    rd(8'h55);
    chk(d, 8'h00, "unmapped");
    // status fields take no writes, share and accessory do
    repeat (4) begin
      seed = lfsr(seed);
      wr(8'h09, {5'h1D, seed[2:0]});
      rd(8'h09);
      chk(d & 8'hEF, 8'h20 | seed[2:0], "status write");
      chk(change_alert_n, !d[4], "alert flag");
      wr(8'h09, 8'h10 | seed[2:0]);
      rd(8'h09);
      chk({d[4], change_alert_n}, 2'h1, "flag clear");
    end
    wr(8'h0A, 8'hC0);
    @(negedge mclk);
    chk(change_alert_n, 1'b0, "alert on change");
    rd(8'h09);
    chk(d[4], 1'b1, "flag held");
    wr(8'h09, 8'h10 | seed[2:0]);
    $display("test register access done");
    // every settle code, both orientations
    for (int s = 0; s < 4; s++) begin
      n = 20 + 10 * s;
      wr(8'h0A, {s[1:0], 6'h00});
      want_attach = 2'h2;
      want_orient = s[0];
      repeat (n - 6) @(negedge mclk);
      rd(8'h09);
      chk(d[7:6], 2'h0, "early attach");
      repeat (12) @(negedge mclk);
      rd(8'h09);
      chk(d[7:5], {2'h2, s[0]}, "attach");
      chk(attach_indicator_pin, 2'h2, "pin");
      wr(8'h0A, {s[1:0], 6'h10});
      rd(8'h0A);
      chk(d[5:4], 2'h0, "role while attached");
      want_attach = 2'h0;
      repeat (n + 12) @(negedge mclk);
    end
    want_trip = 1'b1;
    @(negedge mclk);
    want_trip = 1'b0;
    repeat (3) @(negedge mclk);
    rd(8'h09);
    chk(d[3], 1'b1, "overcurrent");
    $display("test cc_settle_time done");
    // soft reset drops a live attach
    want_attach = 2'h3;
    repeat (62) @(negedge mclk);
    rd(8'h09);
    chk(d[7:6], 2'h3, "accessory attach");
    wr(8'h0A, 8'hC8);
    repeat (2) @(negedge mclk);
    chk(logic_reset, 1'b1, "soft reset on");
    n = 0;
    while (logic_reset === 1'b1 && n < 40) begin
      @(negedge mclk);
      n++;
    end
    if (n == 40) begin
      chk(8'h00, 8'h01, "soft reset stuck");
      test_done();
    end
    rd(8'h0A);
    chk(d[3], 1'b0, "soft reset self clear");
    rd(8'h09);
    chk(d[7:5], 3'h1, "soft reset status");
    want_attach = 2'h0;
    repeat (70) @(negedge mclk);
    $display("test soft reset done");
    // roles, straps, accessory, preference
    role_strap = 2'h1;
    for (int r = 0; r < 4; r++) begin
      wr(8'h0A, {2'h0, r[1:0], 4'h0});
      repeat (2) @(negedge mclk);
      chk(active_role, exp_role(r[1:0]), "role");
    end
    i2c_mode_strap = 1'b0;
    wr(8'h0A, 8'h20);
    repeat (2) @(negedge mclk);
    chk(active_role, 2'h1, "strap role");
    i2c_mode_strap = 1'b1;
    wr(8'h0A, 8'h10);
    wr(8'h09, 8'h01);
    repeat (2) @(negedge mclk);
    chk({accessory_allow, source_advertise}, 2'h0, "sink acc off");
    wr(8'h09, 8'h00);
    repeat (2) @(negedge mclk);
    chk(accessory_allow, 1'b1, "sink acc on");
    role_strap = 2'h0;
    for (int p = 0; p < 4; p++) begin
      wr(8'h0A, {5'h00, p[1:0], 1'b0});
      repeat (2) @(negedge mclk);
      chk(try_mode, exp_try(p[1:0]), "try mode");
    end
    wr(8'h0A, 8'h00);
    $display("test roles done");
    // source share over one whole toggle period
    for (int s = 0; s < 4; s++) begin
      wr(8'h09, {5'h00, s[1:0], 1'b0});
      repeat (100) @(negedge mclk);
      n = 0;
      repeat (100) begin
        @(negedge mclk);
        if (source_advertise === 1'b1) begin
          n++;
        end
      end
      chk(n[7:0], 8'(30 + 10 * s), "share");
    end
    wr(8'h0A, 8'h01);
    repeat (2) @(negedge mclk);
    chk(cc_term_on, 1'b0, "term off");
    wr(8'h0A, 8'h00);
    repeat (2) @(negedge mclk);
    chk(cc_term_on, 1'b1, "term on");
    $display("test share and termination done");
    test_done();
  end
endmodule // typec_port_status_control_test
